// ### design/trace_jtag_access.sv
/*
  TAP controller with scan chain select and the 40-bit trace register
  chain. TCK, TMS, TDI and TRST_n come from the probe's clock domain
  and reach the logic through flip-flops on i_clock: three stages for
  TCK so that its edges can be found, two for the others.
  A TCK edge on the pin acts at the third rising edge of i_clock after
  it: the TAP state, the register strobe and TDO all move there, so
  the probe must leave that long before it samples TDO.
  Assumes TCK stays below a quarter of i_clock, with each phase at
  least two clocks long, and TMS and TDI steady around each rise.
  Assumes the trace register set answers reads combinationally via
  i_reg_rdata for the address on o_reg.addr in the cycle of o_reg.rd.
  TRST_n parks the TAP but leaves the chain and the read buffer alone.
  No bypass register: with no chain selected TDO shows the select.
*/
`timescale 1ns/1ps
`include "trace_jtag_map.svh"
module trace_jtag_access (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst,
  input  wire logic                   i_tck,
  input  wire logic                   i_tms,
  input  wire logic                   i_tdi,
  input  wire logic                   i_trst_n,
  input  wire logic [`TJ_DATA_W-1:0]  i_reg_rdata,
  output logic                        o_tdo,
  output logic                        o_tdo_en,
  output trace_jtag_pkg::reg_req_t    o_reg
);

  // State and edge strobes
  trace_jtag_pkg::state_t q;         // Registered state
  trace_jtag_pkg::state_t d;         // Next state
  logic                   rise;      // Synchronised TCK rise, one cycle
  logic                   fall;      // Synchronised TCK fall, one cycle
  logic                   sel_ok;    // Trace chain is the active DR
  logic                   in_scan_n; // Select register is the active DR

  // Edge finding only on the second and third sampled stages; the
  // first stage may still be settling, so only the shift reads it
  assign rise      = q.tck_s[1] & ~q.tck_s[2];
  assign fall      = ~q.tck_s[1] & q.tck_s[2];
  // Which data register a DR scan reaches
  assign in_scan_n = (q.ir == `TJ_IR_SCAN_N);
  assign sel_ok    = (q.ir == `TJ_IR_INTEST) &&
                     (q.sel == `TJ_CHAIN_SEL);

  // Next state: every field holds unless a branch below moves it
  always_comb begin
    d          = q;
    // Pin stages shift every clock
    d.tck_s    = {q.tck_s[1:0], i_tck};
    d.tms_s    = {q.tms_s[0], i_tms};
    d.tdi_s    = {q.tdi_s[0], i_tdi};
    d.trst_n_s = {q.trst_n_s[0], i_trst_n};
    // Strobes are one-cycle pulses; fields hold until the next update
    d.req.wr   = 1'h0;
    d.req.rd   = 1'h0;
    // Read data is taken at the end of the strobe cycle, which gives
    // the register set the whole cycle to answer for o_reg.addr
    if (q.req.rd) begin
      d.rdata = i_reg_rdata;
    end
    // TAP reset wins over a TCK edge found in the same cycle
    if (!q.trst_n_s[1]) begin
      d.st     = trace_jtag_pkg::TLR;
      d.ir     = `TJ_IR_RESET;
      d.sel    = '0;
      d.tdo_en = 1'h0;
    end else if (rise) begin
      // Shift on rising TCK, then advance the state
      unique case (q.st)
        trace_jtag_pkg::CDR: begin
          // Address and direction capture zero, so an update with no
          // new bits shifted in is only a read of register zero
          if (sel_ok) begin
            d.chain = {`TJ_CHAIN_W{1'h0}};
            d.chain[`TJ_DATA_W-1:0] = q.rdata;
          end
          d.sel_sh = q.sel;
        end
        // LSB first toward TDO; with IR at SCAN_N the select shifts
        trace_jtag_pkg::SDR: begin
          if (sel_ok) begin
            d.chain = {q.tdi_s[1], q.chain[`TJ_CHAIN_W-1:1]};
          end else if (in_scan_n) begin
            d.sel_sh = {q.tdi_s[1], q.sel_sh[`TJ_SEL_W-1:1]};
          end
        end
        // IR capture pattern leads the IR shift out on TDO
        trace_jtag_pkg::CIR: begin
          d.ir_sh = 4'h1;
        end
        trace_jtag_pkg::SIR: begin
          d.ir_sh = {q.tdi_s[1], q.ir_sh[`TJ_IR_W-1:1]};
        end
        // Update work is done on entry, below, not in the state itself
        trace_jtag_pkg::UIR: ;
        trace_jtag_pkg::UDR: ;
        default: ;
      endcase
      d.st = next_st(q.st, q.tms_s[1]);
      // Actions on entry to an update state, never during shift
      if (d.st == trace_jtag_pkg::UIR) begin
        d.ir = d.ir_sh;
      end
      if (d.st == trace_jtag_pkg::UDR) begin
        // Select register or trace access, from the bits just shifted
        if (in_scan_n) begin
          d.sel = q.sel_sh;
        end else if (sel_ok) begin
          d.req.addr = q.chain[`TJ_ADDR_LSB +: `TJ_ADDR_W];
          d.req.data = q.chain[`TJ_DATA_LSB +: `TJ_DATA_W];
          d.req.wr   = q.chain[`TJ_RW_BIT];
          d.req.rd   = ~q.chain[`TJ_RW_BIT];
        end
      end
      // Entering Test-Logic-Reset by TMS drops IR and select too
      if (d.st == trace_jtag_pkg::TLR) begin
        d.ir  = `TJ_IR_RESET;
        d.sel = '0;
      end
    end else if (fall) begin
      // TDO changes on falling TCK so it is settled well before the
      // probe's next rise
      d.tdo_en = (q.st == trace_jtag_pkg::SDR) ||
                 (q.st == trace_jtag_pkg::SIR);
      if (q.st == trace_jtag_pkg::SIR) begin
        d.tdo = q.ir_sh[0];
      end else if (sel_ok) begin
        d.tdo = q.chain[0];
      end else begin
        d.tdo = q.sel_sh[0];
      end
    end
  end

  // Standard TAP state transitions, TMS taken at the TCK rise
  function automatic trace_jtag_pkg::tap_state_t next_st(
    input trace_jtag_pkg::tap_state_t s,
    input logic                        tms
  );
    unique case (s)
      // Reset and idle
      trace_jtag_pkg::TLR: begin
        next_st = tms ? trace_jtag_pkg::TLR : trace_jtag_pkg::RTI;
      end
      trace_jtag_pkg::RTI: begin
        next_st = tms ? trace_jtag_pkg::SDRS : trace_jtag_pkg::RTI;
      end
      // Data register column
      trace_jtag_pkg::SDRS: begin
        next_st = tms ? trace_jtag_pkg::SIRS : trace_jtag_pkg::CDR;
      end
      trace_jtag_pkg::CDR: begin
        next_st = tms ? trace_jtag_pkg::E1DR : trace_jtag_pkg::SDR;
      end
      trace_jtag_pkg::SDR: begin
        next_st = tms ? trace_jtag_pkg::E1DR : trace_jtag_pkg::SDR;
      end
      trace_jtag_pkg::E1DR: begin
        next_st = tms ? trace_jtag_pkg::UDR : trace_jtag_pkg::PDR;
      end
      // Pause lets the probe stall a scan without losing bits
      trace_jtag_pkg::PDR: begin
        next_st = tms ? trace_jtag_pkg::E2DR : trace_jtag_pkg::PDR;
      end
      trace_jtag_pkg::E2DR: begin
        next_st = tms ? trace_jtag_pkg::UDR : trace_jtag_pkg::SDR;
      end
      trace_jtag_pkg::UDR: begin
        next_st = tms ? trace_jtag_pkg::SDRS : trace_jtag_pkg::RTI;
      end
      // Instruction register column
      trace_jtag_pkg::SIRS: begin
        next_st = tms ? trace_jtag_pkg::TLR : trace_jtag_pkg::CIR;
      end
      trace_jtag_pkg::CIR: begin
        next_st = tms ? trace_jtag_pkg::E1IR : trace_jtag_pkg::SIR;
      end
      trace_jtag_pkg::SIR: begin
        next_st = tms ? trace_jtag_pkg::E1IR : trace_jtag_pkg::SIR;
      end
      trace_jtag_pkg::E1IR: begin
        next_st = tms ? trace_jtag_pkg::UIR : trace_jtag_pkg::PIR;
      end
      trace_jtag_pkg::PIR: begin
        next_st = tms ? trace_jtag_pkg::E2IR : trace_jtag_pkg::PIR;
      end
      trace_jtag_pkg::E2IR: begin
        next_st = tms ? trace_jtag_pkg::UIR : trace_jtag_pkg::SIR;
      end
      trace_jtag_pkg::UIR: begin
        next_st = tms ? trace_jtag_pkg::SDRS : trace_jtag_pkg::RTI;
      end
      // Only an illegal code lands here; fall back to reset
      default: begin
        next_st = trace_jtag_pkg::TLR;
      end
    endcase
  endfunction

  // Single state register; reset parks TAP in logic reset
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      // Pin stages start at their idle levels, TCK low and TRST_n
      // high, so no false edge or TAP reset follows the release
      q          <= '0;
      q.st       <= trace_jtag_pkg::TLR;
      q.ir       <= `TJ_IR_RESET;
      q.trst_n_s <= 2'h3;
    end else begin
      q <= d;
    end
  end

  // Every output straight from the state register
  assign o_tdo    = q.tdo;
  assign o_tdo_en = q.tdo_en;
  assign o_reg    = q.req;

endmodule // trace_jtag_access

// ### design/trace_jtag_map.svh
/*
  Constants for the trace register scan chain: field positions, widths,
  chain select and instruction codes.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef TRACE_JTAG_MAP_SVH
`define TRACE_JTAG_MAP_SVH

`define TJ_CHAIN_SEL      4'h6
`define TJ_CHAIN_W        40
`define TJ_DATA_W         32
`define TJ_ADDR_W         7
`define TJ_DATA_LSB       0
`define TJ_ADDR_LSB       32
`define TJ_RW_BIT         39
`define TJ_SEL_W          4
`define TJ_IR_W           4
`define TJ_IR_SCAN_N      4'h2
`define TJ_IR_INTEST      4'hC
`define TJ_IR_RESET       4'hF

`endif

// ### design/trace_jtag_pkg.sv
/*
  Types for the trace register scan chain access block.
  Assumes trace_jtag_map.svh is on the include path.
*/
`include "trace_jtag_map.svh"
package trace_jtag_pkg;

  // TAP controller states, one-hot
  typedef enum logic [15:0] {
    TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
    SDR  = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
    UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SIR  = 16'h0800,
    E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
  } tap_state_t;

  // One register access toward the trace unit
  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`TJ_ADDR_W-1:0]  addr;
    logic [`TJ_DATA_W-1:0]  data;
  } reg_req_t;

  // Whole module state
  typedef struct packed {
    logic [2:0]             tck_s;
    logic [1:0]             tms_s;
    logic [1:0]             tdi_s;
    logic [1:0]             trst_n_s;
    tap_state_t             st;
    logic [`TJ_IR_W-1:0]    ir_sh;
    logic [`TJ_IR_W-1:0]    ir;
    logic [`TJ_SEL_W-1:0]   sel_sh;
    logic [`TJ_SEL_W-1:0]   sel;
    logic [`TJ_CHAIN_W-1:0] chain;
    logic [`TJ_DATA_W-1:0]  rdata;
    logic                   tdo;
    logic                   tdo_en;
    reg_req_t               req;
  } state_t;

endpackage

// ### test/jtag_probe.sv
/* Debug probe model: drives TCK, TMS, TDI and TRST_n of the TAP.
   Assumes i_clock at 40 ns; TCK is 8 clocks and idles low. */
`timescale 1ns/1ps
module jtag_probe (
  input  wire logic i_clock,
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_trst_n
);
  // Brief TAP reset pulse at power-up
  initial begin
    {o_tck, o_tms, o_tdi, o_trst_n} = 4'h2;
    repeat (4) @(negedge i_clock);
    o_trst_n = 1'h1;
  end
  // One TCK period; TMS/TDI move while TCK is low, TDO read before rise
  task automatic tick(input logic tms, tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clock);
    tdo = i_tdo;
    o_tck = 1'h1;
    repeat (4) @(negedge i_clock);
    o_tck = 1'h0;
  endtask
  // Idle, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
                      output logic [39:0] dout);
    logic b;
    dout = 40'h0;
    tick(1'h0, 1'h0, b);
    tick(1'h1, 1'h0, b);
    if (ir) tick(1'h1, 1'h0, b);
    tick(1'h0, 1'h0, b);
    tick(1'h0, 1'h0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'h1, 1'h0, b);
    tick(1'h0, 1'h0, b);
  endtask
endmodule // jtag_probe

// ### test/trace_jtag_access_sva.sv
/* Port checker for trace_jtag_access, bound to every instance.
   Assumes TCK stays at least 8 clocks per period. */
`timescale 1ns/1ps
module trace_jtag_access_sva (
  input wire logic                     i_clock,
  input wire logic                     i_rst,
  input wire logic                     i_tck,
  input wire logic                     i_tms,
  input wire logic                     o_tdo_en,
  input wire trace_jtag_pkg::reg_req_t o_reg
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic acc;
  // Either strobe counts as an access
  assign acc = o_reg.wr | o_reg.rd;
  a_strobe_pulse: assert property (acc |=> !acc)
    else $error("strobe longer than one cycle");
  a_rw_exclusive: assert property (!(o_reg.wr && o_reg.rd))
    else $error("read and write strobe together");
  // Only an Update-DR entry: TCK high, TMS high since the rise
  a_update_entry: assert property (acc |-> i_tck && $past(i_tck, 2)
    && $past(i_tms, 2)) else $error("access outside update");
  a_fields_hold: assert property (!acc |-> $stable(o_reg.addr)
    && $stable(o_reg.data)) else $error("fields moved without access");
  a_shift_enable: assert property ($rose(o_tdo_en) |-> !i_tck
    && !$past(i_tck, 2)) else $error("TDO enabled off a TCK fall");
  c_write: cover property (o_reg.wr);
  c_read: cover property (o_reg.rd);
  c_shift: cover property ($rose(o_tdo_en));
endmodule // trace_jtag_access_sva
bind trace_jtag_access trace_jtag_access_sva u_sva (.i_clock(i_clock),
  .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms), .o_tdo_en(o_tdo_en),
  .o_reg(o_reg));

// ### test/trace_reg_jtag_access_test.sv
/* Bench for trace_jtag_access driven through the probe model.
   Assumes read data may follow o_reg.addr combinationally. */
`timescale 1ns/1ps
`include "trace_jtag_map.svh"
module trace_reg_jtag_access_test;
  logic                     i_clock = 1'h0;
  logic                     i_rst = 1'h1;
  logic                     tck, tms, tdi, trst_n, tdo, tdo_en;
  logic [31:0]              rdata;
  logic [39:0]              got, seen;
  trace_jtag_pkg::reg_req_t req;
  int                       n_mismatch = 0, n_tests = 0, n_acc = 0;
  initial forever #20 i_clock = ~i_clock;
  // Register set stand-in: value derived from the address
  assign rdata = {25'h1ABCDE5, req.addr};
  // Record every access as {wr, addr, data}, mid-cycle where settled
  always @(negedge i_clock) if (req.wr === 1'h1 || req.rd === 1'h1) begin
    n_acc <= n_acc + 1;
    seen <= {req.wr, req.addr, req.data};
  end
  trace_jtag_access DUT (.i_clock(i_clock), .i_rst(i_rst), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .i_reg_rdata(rdata),
    .o_tdo(tdo), .o_tdo_en(tdo_en), .o_reg(req));
  jtag_probe probe (.i_clock(i_clock), .i_tdo(tdo), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
  task automatic chk(input logic [39:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic final_report;
    $display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Point DR scans at chain sel, then load INTEST to scan that chain
  task automatic pick(input logic [3:0] sel);
    probe.scan(1'h1, 4, 40'(`TJ_IR_SCAN_N), got);
    probe.scan(1'h0, 4, 40'(sel), got);
    probe.scan(1'h1, 4, 40'(`TJ_IR_INTEST), got);
  endtask
  // One 40-bit scan; a stray strobe mid-shift shows as a wrong count
  task automatic access(input logic [39:0] w, input int want);
    int i;
    probe.scan(1'h0, 40, w, got);
    chk(40'(tdo_en), 40'h0);
    for (i = 0; i < 20 && n_acc != want; i++) @(negedge i_clock);
    chk(40'(n_acc), 40'(want));
    if (n_acc != want) final_report;
  endtask
  task automatic t_write;
    pick(4'h6);
    access({1'h1, 7'h7F, 32'hDEADBEEF}, n_acc + 1);
    chk(seen, {1'h1, 7'h7F, 32'hDEADBEEF});
    access({1'h1, 7'h00, 32'h00000001}, n_acc + 1);
    chk(seen, {1'h1, 7'h00, 32'h00000001});
  endtask
  // Data field ignored; result comes back on the next scan
  task automatic t_read;
    pick(4'h6);
    access({1'h0, 7'h15, 32'hFFFFFFFF}, n_acc + 1);
    chk({seen[39:32], 32'h0}, {1'h0, 7'h15, 32'h0});
    access({1'h0, 7'h2A, 32'h0}, n_acc + 1);
    chk(got, {8'h00, 25'h1ABCDE5, 7'h15});
  endtask
  // Chain not selected: a full write scan gives no strobe
  task automatic t_unsel;
    pick(4'h3);
    access({1'h1, 7'h01, 32'h00000001}, n_acc);
  endtask
  initial begin
    repeat (3) @(negedge i_clock);
    i_rst = 1'h0;
    repeat (4) @(negedge i_clock);
    t_write;
    t_read;
    t_unsel;
    final_report;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(negedge i_clock);
    n_mismatch++;
    final_report;
  end
endmodule // trace_reg_jtag_access_test
